// ===== rtl/ophs_pkg.sv
// shared constants, modes and carriers of the output port handshake block
package ophs_pkg;

  // ==========================================================
  // widths and depths
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SKEW_W     = 4;
  localparam int TIMER_W    = 16;
  localparam int SYNC_W     = 2;

  // ==========================================================
  // reset values
  localparam logic RST_DATA_AVAIL_N = 1'b1;
  localparam logic RST_FULL         = 1'b0;
  localparam logic [DATA_W-1:0]  RST_DATA   = 8'h00;
  localparam logic [SKEW_W-1:0]  RST_SKEW   = 4'h0;
  localparam logic [TIMER_W-1:0] RST_TIMER  = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE  = 16'h0001;
  localparam logic [SKEW_W-1:0]  SKEW_ZERO  = 4'h0;
  localparam logic [SKEW_W-1:0]  SKEW_ONE   = 4'h1;

  // ==========================================================
  // handshake types and counter duty cycles
  typedef enum logic [1:0] {
    OPHS_HS_INTERLOCKED,
    OPHS_HS_STROBED,
    OPHS_HS_PULSED,
    OPHS_HS_THREE_WIRE
  } ophs_hs_t;

  typedef enum logic [1:0] {
    OPHS_DUTY_PULSE,
    OPHS_DUTY_ONE_SHOT,
    OPHS_DUTY_SQUARE
  } ophs_duty_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    ophs_hs_t            mode;
    ophs_duty_t          duty;
    logic                skew_delay_enable;
    logic [SKEW_W-1:0]   skew_time;
    logic [TIMER_W-1:0]  timer_reload_value;
  } ophs_cfg_t;

  typedef struct packed {
    logic output_empty_flag;
    logic buffer_full;
    logic skew_running;
    logic timer_claim;
  } ophs_status_t;

endpackage

// ===== rtl/ophs_fifo.sv
// small write-side fifo with registered read data
`timescale 1ns/1ps
module ophs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("ophs_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  // push while not full; refill output stage when it is free
  wire push    = in_valid & in_ready;
  wire stage_free = ~out_valid_reg | out_ready;
  wire pull    = stage_free & (count_reg != '0);

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;

  // storage has no reset; pointers, count and output register do
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers, count and output register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pull) begin
        rd_ptr_reg    <= rd_ptr_reg + 1'b1;
        out_data_reg  <= mem[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pull);
    end
  end
endmodule

// ===== rtl/ophs_deskew.sv
// per-port deskew timer counted in clock cycles
`timescale 1ns/1ps
module ophs_deskew #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // control
  input  wire logic         start,
  input  wire logic [W-1:0] time_const,
  // status
  output logic              running,
  output logic              done
);
  if (W < 1 || W > 8) begin : g_chk
    $error("ophs_deskew: W must lie between 1 and 8");
  end

  logic [W-1:0] cnt_reg;
  logic         run_reg;
  logic         done_reg;

  assign running = run_reg;
  assign done    = done_reg;

  // a start loads time_const; expiry after time_const+1 cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else if (start) begin
      cnt_reg  <= time_const;
      run_reg  <= 1'b1;
      done_reg <= 1'b0;
    end else if (run_reg) begin
      if (cnt_reg == '0) begin
        run_reg  <= 1'b0;
        done_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ===== rtl/ophs_port.sv
// output port handshake: data path, interlock and strobe shaping
// ==========================================================
// How it works
// - loading the buffer with skew enabled starts the deskew countdown
// - strobe stays high until deskew time, up to 16 cycles, elapses
// - deskew counts only from buffer load, never from acknowledge rising
// - this port owns its own 4-bit deskew timer, usable in every mode
// - interlocked strobe never falls while the acknowledge input is low
// - with buffer empty, a byte moves on to pins and the fifo refills the register if it holds a byte
// - a byte written into the output data register clears empty flag
// - acknowledge falling empties buffer, raises strobe, then reloads
// - strobed mode drops the strobe at deskew end regardless of acknowledge
// - pulsed mode feeds internal strobe through timer, output inverted
// - pulsed interlock and deskew act on the internal strobe
// - pulsed handshake only while no other port holds the shared timer
// - pulse duty: strobe falls count cycles after edge, lasts one cycle
// - one-shot duty: strobe falls at once, rises count cycles later
// - square duty: strobe falls after count cycles, stays low that long
// - three-wire waits for accepted low and ready high before lowering
// - three-wire lowers strobe at deskew end, or at once when disabled
// - accepted rising empties buffer, raises strobe, allows reload
`timescale 1ns/1ps
module ophs_port #(
  parameter int DATA_W     = ophs_pkg::DATA_W,
  parameter int FIFO_DEPTH = ophs_pkg::FIFO_DEPTH,
  parameter int TIMER_W    = ophs_pkg::TIMER_W
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // host byte stream
  input  wire logic                host_valid,
  output logic                     host_ready,
  input  wire logic [DATA_W-1:0]   host_data,
  // configuration
  input  wire ophs_pkg::ophs_cfg_t cfg,
  input  wire logic                timer_held_elsewhere,
  // status
  output ophs_pkg::ophs_status_t   status,
  // port pins
  output logic [DATA_W-1:0]        port_data,
  output logic                     data_avail_n,
  input  wire logic                acknowledge_input,
  input  wire logic                ready_for_data,
  input  wire logic                data_accepted
);
  // ==========================================================
  // parameter checks
  if (DATA_W != ophs_pkg::DATA_W) begin : g_chk_w
    $error("ophs_port: DATA_W must match the package width");
  end
  if (TIMER_W != ophs_pkg::TIMER_W) begin : g_chk_t
    $error("ophs_port: TIMER_W must match the package width");
  end

  // ==========================================================
  // pin synchronisers
  logic [ophs_pkg::SYNC_W-1:0] ack_sync_reg;
  logic [ophs_pkg::SYNC_W-1:0] rfd_sync_reg;
  logic [ophs_pkg::SYNC_W-1:0] dac_sync_reg;
  logic                        ack_prev_reg;
  logic                        dac_prev_reg;

  // two flops each; only the second stage is read below
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_sync_reg <= '1;
      rfd_sync_reg <= '0;
      dac_sync_reg <= '0;
      ack_prev_reg <= 1'b1;
      dac_prev_reg <= 1'b0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], acknowledge_input};
      rfd_sync_reg <= {rfd_sync_reg[0], ready_for_data};
      dac_sync_reg <= {dac_sync_reg[0], data_accepted};
      ack_prev_reg <= ack_sync_reg[1];
      dac_prev_reg <= dac_sync_reg[1];
    end
  end

  wire ack_s    = ack_sync_reg[1];
  wire rfd_s    = rfd_sync_reg[1];
  wire dac_s    = dac_sync_reg[1];
  wire ack_fall = ack_prev_reg & ~ack_s;
  wire dac_rise = ~dac_prev_reg & dac_s;

  // ==========================================================
  // mode decode
  wire mode_interlocked = (cfg.mode == ophs_pkg::OPHS_HS_INTERLOCKED);
  wire mode_strobed     = (cfg.mode == ophs_pkg::OPHS_HS_STROBED);
  wire mode_pulsed      = (cfg.mode == ophs_pkg::OPHS_HS_PULSED);
  wire mode_three_wire  = (cfg.mode == ophs_pkg::OPHS_HS_THREE_WIRE);

  wire timer_ok = mode_pulsed & ~timer_held_elsewhere;

  // ==========================================================
  // write-side fifo
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_take;

  ophs_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (host_valid),
    .in_ready  (host_ready),
    .in_data   (host_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  // ==========================================================
  // output data register and buffer register
  logic              odr_full_reg;
  logic [DATA_W-1:0] odr_data_reg;
  logic              buf_full_reg;
  logic [DATA_W-1:0] buf_data_reg;

  // the receiver releases the byte: ack falls, or accepted rises
  wire release_evt = buf_full_reg &
                     (mode_three_wire ? dac_rise : ack_fall);
  // reload happens the cycle after release, once the buffer reads empty
  wire buf_load    = ~buf_full_reg & odr_full_reg;
  // the fifo stalls while the output data register and the buffer are both occupied
  assign fifo_take = ~odr_full_reg | buf_load;

  // host byte fills the output data register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      odr_full_reg <= ophs_pkg::RST_FULL;
      odr_data_reg <= ophs_pkg::RST_DATA;
    end else if (fifo_take) begin
      odr_full_reg <= fifo_valid;
      if (fifo_valid) odr_data_reg <= fifo_data;
    end
  end

  // move byte into buffer and onto pins
  // release empties buffer; accepted rising does the same
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_full_reg <= ophs_pkg::RST_FULL;
      buf_data_reg <= ophs_pkg::RST_DATA;
    end else if (buf_load) begin
      buf_full_reg <= 1'b1;
      buf_data_reg <= odr_data_reg;
    end else if (release_evt) begin
      buf_full_reg <= 1'b0;
    end
  end

  assign port_data = buf_data_reg;

  // ==========================================================
  // deskew timer
  logic skew_running;
  logic skew_done;

  // countdown starts on buffer load when enabled
  ophs_deskew #(
    .W (ophs_pkg::SKEW_W)
  ) u_deskew (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .start      (buf_load & cfg.skew_delay_enable),
    .time_const (cfg.skew_time),
    .running    (skew_running),
    .done       (skew_done)
  );

  // done stays set after expiry so ack rising adds no delay
  wire skew_ok = ~cfg.skew_delay_enable | skew_done;

  // ==========================================================
  // interlock and internal strobe
  // interlocked and pulsed wait for ack high
  // strobed ignores ack; three-wire needs dac low, rfd high
  wire interlock_ok = (mode_interlocked & ack_s) |
                      mode_strobed |
                      (timer_ok & ack_s) |
                      (mode_three_wire & ~dac_s & rfd_s);

  // strobe low only once deskew has elapsed
  wire dav_fall_ok = buf_full_reg & ~release_evt & skew_ok & interlock_ok;

  logic dav_int_reg;
  logic dav_int_prev_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dav_int_reg      <= ophs_pkg::RST_DATA_AVAIL_N;
      dav_int_prev_reg <= ophs_pkg::RST_DATA_AVAIL_N;
    end else begin
      dav_int_prev_reg <= dav_int_reg;
      if (~buf_full_reg | release_evt) begin
        dav_int_reg <= 1'b1;
      end else if (dav_fall_ok) begin
        dav_int_reg <= 1'b0;
      end
    end
  end

  wire dav_int_fall = dav_int_prev_reg & ~dav_int_reg;

  // ==========================================================
  // shared counter/timer stage for pulsed mode
  typedef enum logic [1:0] {
    OPHS_CT_IDLE,
    OPHS_CT_WAIT,
    OPHS_CT_LOW
  } ophs_ct_state_t;

  ophs_ct_state_t       ct_state_reg;
  ophs_ct_state_t       ct_state_next;
  logic [TIMER_W-1:0]   ct_cnt_reg;
  logic [TIMER_W-1:0]   ct_cnt_next;

  // a zero count is served as one cycle so the strobe still pulses
  wire [TIMER_W-1:0] tc_eff = (cfg.timer_reload_value == '0) ?
                              ophs_pkg::TIMER_ONE : cfg.timer_reload_value;
  wire duty_one_shot = (cfg.duty == ophs_pkg::OPHS_DUTY_ONE_SHOT);
  wire duty_pulse    = (cfg.duty == ophs_pkg::OPHS_DUTY_PULSE);
  wire ct_last       = (ct_cnt_reg == ophs_pkg::TIMER_ONE);

  // timer triggered on internal falling edge
  always_comb begin
    ct_state_next = ct_state_reg;
    ct_cnt_next   = ct_cnt_reg;
    case (ct_state_reg)
      OPHS_CT_IDLE: begin
        if (timer_ok & dav_int_fall) begin
          ct_cnt_next   = tc_eff;
          ct_state_next = duty_one_shot ? OPHS_CT_LOW : OPHS_CT_WAIT;
        end
      end
      OPHS_CT_WAIT: begin
        if (ct_last) begin
          ct_state_next = OPHS_CT_LOW;
          ct_cnt_next   = duty_pulse ? ophs_pkg::TIMER_ONE : tc_eff;
        end else begin
          ct_cnt_next = ct_cnt_reg - 1'b1;
        end
      end
      OPHS_CT_LOW: begin
        if (ct_last) begin
          ct_state_next = OPHS_CT_IDLE;
          ct_cnt_next   = ophs_pkg::RST_TIMER;
        end else begin
          ct_cnt_next = ct_cnt_reg - 1'b1;
        end
      end
      default: begin
        ct_state_next = OPHS_CT_IDLE;
        ct_cnt_next   = ophs_pkg::RST_TIMER;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ct_state_reg <= OPHS_CT_IDLE;
      ct_cnt_reg   <= ophs_pkg::RST_TIMER;
    end else begin
      ct_state_reg <= ct_state_next;
      ct_cnt_reg   <= ct_cnt_next;
    end
  end

  // ==========================================================
  // pin strobe: inverted timer output in pulsed mode
  logic dav_pin_reg;
  wire  dav_pin_next = timer_ok ? ~(ct_state_next == OPHS_CT_LOW)
                                : dav_int_reg;

  // registered so the pin never glitches between modes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dav_pin_reg <= ophs_pkg::RST_DATA_AVAIL_N;
    end else begin
      dav_pin_reg <= dav_pin_next;
    end
  end

  assign data_avail_n = dav_pin_reg;

  // ==========================================================
  // status
  assign status.output_empty_flag = ~odr_full_reg;
  assign status.buffer_full       = buf_full_reg;
  assign status.skew_running      = skew_running;
  assign status.timer_claim       = timer_ok;
endmodule

// ===== testbench/ophs_port_chk.sv
// timing checker bound to the output port handshake top
`timescale 1ns/1ps
module ophs_port_chk #(
  parameter int DATA_W     = ophs_pkg::DATA_W,
  parameter int FIFO_DEPTH = ophs_pkg::FIFO_DEPTH,
  parameter int TIMER_W    = ophs_pkg::TIMER_W
) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // host side and configuration
  input wire logic                   host_valid,
  input wire logic                   host_ready,
  input wire logic [DATA_W-1:0]      host_data,
  input wire ophs_pkg::ophs_cfg_t    cfg,
  input wire logic                   timer_held_elsewhere,
  input wire ophs_pkg::ophs_status_t status,
  // port pins
  input wire logic [DATA_W-1:0]      port_data,
  input wire logic                   data_avail_n,
  input wire logic                   acknowledge_input,
  input wire logic                   ready_for_data,
  input wire logic                   data_accepted
);
  // ==========================================================
  // mode decode and expected figures
  logic [4:0]         full_cnt;
  logic [TIMER_W-1:0] low_cnt;
  wire il = cfg.mode == ophs_pkg::OPHS_HS_INTERLOCKED;
  wire sb = cfg.mode == ophs_pkg::OPHS_HS_STROBED;
  wire pl = cfg.mode == ophs_pkg::OPHS_HS_PULSED;
  wire tw = cfg.mode == ophs_pkg::OPHS_HS_THREE_WIRE;
  // strobe falls 2 edges after load, deskew adds skew_time+1
  wire [4:0] fall_at = cfg.skew_delay_enable ?
                       {1'b0, cfg.skew_time} + 5'h3 : 5'h2;
  wire [TIMER_W-1:0] low_len = (cfg.duty == ophs_pkg::OPHS_DUTY_PULSE) ?
                               TIMER_W'(1) : cfg.timer_reload_value;

  // cycles since buffer load (saturating) and strobe low length
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_cnt <= 5'h00;
      low_cnt  <= '0;
    end else begin
      full_cnt <= !status.buffer_full ? 5'h00 :
                  full_cnt + {4'h0, full_cnt != 5'h1F};
      low_cnt  <= data_avail_n ? '0 : low_cnt + TIMER_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // properties
  property p_idle;
    $fell(rst) |-> data_avail_n && status.output_empty_flag &&
      !status.buffer_full && !status.skew_running && host_ready;
  endproperty
  a_idle: assert property (p_idle) else $error("bad state after reset");
  property p_skew;
    $fell(data_avail_n) && !pl |-> full_cnt >= fall_at;
  endproperty
  a_skew: assert property (p_skew) else $error("strobe before deskew");
  property p_strobed;
    $fell(data_avail_n) && sb |-> full_cnt == fall_at;
  endproperty
  a_strobed: assert property (p_strobed) else $error("strobed fall late");
  property p_lock;
    (il && !acknowledge_input)[*8] |-> data_avail_n;
  endproperty
  a_lock: assert property (p_lock) else $error("strobe low, ack low");
  property p_release;
    $fell(acknowledge_input) && !data_avail_n && !pl && !tw
      |-> ##[2:6] data_avail_n;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_quick;
    il && $rose(acknowledge_input) && status.buffer_full && data_avail_n
      && full_cnt > 5'h14 |-> ##[2:6] !data_avail_n;
  endproperty
  a_quick: assert property (p_quick) else $error("ack to strobe slow");
  property p_lock3;
    (tw && !ready_for_data)[*8] |-> data_avail_n;
  endproperty
  a_lock3: assert property (p_lock3) else $error("strobe low, rfd low");
  property p_width;
    pl && $rose(data_avail_n) |-> low_cnt == low_len;
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_fill;
    host_valid && host_ready && status.output_empty_flag
      |-> ##[1:3] !status.output_empty_flag;
  endproperty
  a_fill: assert property (p_fill) else $error("empty flag kept");
  property p_skewrun;
    $rose(status.buffer_full) && cfg.skew_delay_enable
      |-> status.skew_running;
  endproperty
  a_skewrun: assert property (p_skewrun) else $error("no deskew");

  // main scenarios seen
  c_strobed: cover property ($fell(data_avail_n) && sb);
  c_pulsed: cover property (pl && $rose(data_avail_n));
  c_three: cover property (tw && $rose(data_accepted));
endmodule

bind ophs_port ophs_port_chk #(
  .DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH), .TIMER_W(TIMER_W)
) u_ophs_port_chk (
  .ref_clk(ref_clk), .rst(rst), .host_valid(host_valid),
  .host_ready(host_ready), .host_data(host_data), .cfg(cfg),
  .timer_held_elsewhere(timer_held_elsewhere), .status(status),
  .port_data(port_data), .data_avail_n(data_avail_n),
  .acknowledge_input(acknowledge_input),
  .ready_for_data(ready_for_data), .data_accepted(data_accepted)
);

// ===== testbench/ophs_rcv_model.sv
// receiving port model: single ack line or ready/accepted pair
`timescale 1ns/1ps
module ophs_rcv_model (
  // clock and control
  input wire logic       ref_clk,
  input wire logic       stall,
  input wire logic [4:0] dly,
  // port pins
  input wire logic       data_avail_n,
  input wire logic [7:0] port_data,
  output logic           acknowledge_input,
  output logic           ready_for_data,
  output logic           data_accepted,
  // taken bytes
  output logic           got_stb,
  output logic [7:0]     got
);
  // one loop serves all modes; stall holds back each new take, but not one already begun
  initial begin
    acknowledge_input = 1'b1;
    ready_for_data    = 1'b1;
    data_accepted     = 1'b0;
    got_stb           = 1'b0;
    got               = 8'h00;
    forever begin
      @(posedge ref_clk);
      if (!data_avail_n && !stall) begin
        repeat (dly) @(posedge ref_clk);
        got     <= port_data;
        got_stb <= 1'b1;
        // taken: ack and rfd low, accepted raised
        acknowledge_input <= 1'b0;
        ready_for_data    <= 1'b0;
        data_accepted     <= 1'b1;
        @(posedge ref_clk);
        got_stb <= 1'b0;
        while (!data_avail_n) @(posedge ref_clk);
        // accepted low first, ready again later
        data_accepted <= 1'b0;
        repeat (dly) @(posedge ref_clk);
        acknowledge_input <= 1'b1;
        ready_for_data    <= 1'b1;
      end
    end
  end
endmodule

// ===== testbench/ophs_port_tb.sv
// self-checking bench of the output port handshake block
`timescale 1ns/1ps
module ophs_port_tb;
  // ==========================================================
  // signals
  logic                   ref_clk;
  logic                   rst;
  logic                   host_valid;
  logic                   host_ready;
  logic [7:0]             host_data;
  ophs_pkg::ophs_cfg_t    cfg;
  logic                   held;
  ophs_pkg::ophs_status_t status;
  logic [7:0]             port_data;
  logic                   data_avail_n;
  logic                   ack;
  logic                   rfd;
  logic                   dac;
  logic                   stall;
  logic [4:0]             dly;
  logic                   got_stb;
  logic [7:0]             got;
  logic [7:0]             exp_q[$];
  int                     n_errors;
  int                     checked;
  int                     cyc;
  int                     w;

  ophs_port u_ophs_port (
    .ref_clk(ref_clk), .rst(rst), .host_valid(host_valid),
    .host_ready(host_ready), .host_data(host_data), .cfg(cfg),
    .timer_held_elsewhere(held), .status(status), .port_data(port_data),
    .data_avail_n(data_avail_n), .acknowledge_input(ack),
    .ready_for_data(rfd), .data_accepted(dac)
  );
  ophs_rcv_model u_ophs_rcv_model (
    .ref_clk(ref_clk), .stall(stall), .dly(dly),
    .data_avail_n(data_avail_n), .port_data(port_data),
    .acknowledge_input(ack), .ready_for_data(rfd),
    .data_accepted(dac), .got_stb(got_stb), .got(got)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, e, s);
    end
  endtask

  // reset picture: {port_data, strobe, empty, full, skew, ready}
  function automatic logic [15:0] idle_word();
    return 16'({ophs_pkg::RST_DATA, ophs_pkg::RST_DATA_AVAIL_N, 1'b1,
                ophs_pkg::RST_FULL, 1'b0, 1'b1});
  endfunction

  task automatic end_sim;
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // reset with a new configuration, then look at the idle state
  task automatic start(input int m, input logic en, input logic [3:0] t);
    rst = 1'b1;
    exp_q.delete();
    cfg.mode = ophs_pkg::ophs_hs_t'(m);
    cfg.skew_delay_enable = en;
    cfg.skew_time = t;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    chk("idle", idle_word(), {port_data, data_avail_n,
        status.output_empty_flag, status.buffer_full,
        status.skew_running, host_ready});
  endtask

  // random bytes with random gaps and receiver delays
  task automatic send(input int n);
    repeat (n) begin
      host_valid = 1'b1;
      host_data = 8'($urandom);
      dly = 5'($urandom);
      w = 0;
      while (host_ready !== 1'b1 && w < 999) begin
        @(negedge ref_clk);
        w++;
      end
      @(negedge ref_clk);
      exp_q.push_back(host_data);
      if ($urandom % 3 == 0) begin
        host_valid = 1'b0;
        @(negedge ref_clk);
      end
    end
    host_valid = 1'b0;
  endtask

  task automatic drain;
    w = 0;
    while (exp_q.size() != 0 && w < 4000) begin
      @(negedge ref_clk);
      w++;
    end
    chk("left", 16'h0, 16'(exp_q.size()));
    repeat (10) @(negedge ref_clk);
    chk("drained", 16'hB, {status.output_empty_flag, status.buffer_full,
        data_avail_n, host_ready});
  endtask

  // bytes leave the port in the order written
  always @(posedge ref_clk) begin
    cyc++;
    if (got_stb === 1'b1) begin
      if (exp_q.size() == 0) chk("extra", 16'h0, 16'h1);
      else chk("byte", exp_q.pop_front(), got);
    end
    if (cyc == 60000) begin
      n_errors++;
      end_sim();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    void'($urandom(32'hFA355824));
    rst = 1'b1;
    host_valid = 1'b0;
    host_data = 8'h00;
    cfg = '0;
    held = 1'b0;
    stall = 1'b0;
    dly = 5'h00;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    // every handshake type with each duty; d=2 is the 16-cycle deskew
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 3; d++) begin
        cfg.duty = ophs_pkg::ophs_duty_t'(d);
        cfg.timer_reload_value = 16'(1 + $urandom % 5);
        start(m, d != 0, (d == 2) ? 4'hF : 4'($urandom));
        send(10);
        drain();
      end
    end
    // receiver stalls until the host side refuses, then drains
    start(0, 1'b1, 4'h0);
    stall = 1'b1;
    host_valid = 1'b1;
    w = 0;
    while (host_ready === 1'b1 && w < 40) begin
      host_data = 8'($urandom);
      exp_q.push_back(host_data);
      w++;
      @(negedge ref_clk);
    end
    host_valid = 1'b0;
    chk("accepted", 16'h1, 16'(w >= ophs_pkg::FIFO_DEPTH));
    chk("stalled", 16'h1, {status.output_empty_flag,
        status.buffer_full});
    stall = 1'b0;
    drain();
    // shared timer owned elsewhere: strobe must stay high
    held = 1'b1;
    start(2, 1'b0, 4'h0);
    send(1);
    repeat (60) @(negedge ref_clk);
    chk("held", 16'h1, 16'(data_avail_n));
    chk("claim", 16'h0, 16'(status.timer_claim));
    held = 1'b0;
    // the claim is a decode, so let it settle before looking
    @(negedge ref_clk);
    chk("claim", 16'h1, 16'(status.timer_claim));
    drain();
    end_sim();
  end
endmodule
